// >>> verilog/cpt_ctrl.sv
// The instruction field positions and the cycle-kind encoding were decided locally.
module cpt_ctrl (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [31:0] instr_addr,
  input  wire logic [31:0] base_value,
  input  wire logic [31:0] src_value,
  input  wire logic        coproc_absent,
  input  wire logic        coproc_busy,
  input  wire logic        coproc_last_word,
  input  wire logic [31:0] coproc_data_in,
  input  wire logic        mem_abort,
  output logic             ctrl_busy,
  output logic             coproc_offer,
  output logic      [31:0] coproc_instr,
  output logic      [31:0] coproc_data_out,
  output logic             coproc_long,
  output logic             mem_req,
  output logic      [31:0] mem_addr,
  output logic      [1:0]  cycle_type,
  output logic             wb_en,
  output logic      [3:0]  wb_reg,
  output logic      [31:0] wb_value,
  output logic             flags_we,
  output logic      [3:0]  flags_nzcv,
  output logic             trap_data_abort,
  output logic             trap_undef,
  output logic             done
);

  // ----------------------------------------------------------------
  // State record.
  // ----------------------------------------------------------------
  typedef struct packed {
    cpt_pkg::cpt_state_e st;
    cpt_pkg::cpt_cycle_e cyc;
    logic [31:0]         instr;
    logic [31:0]         pc;
    logic [31:0]         base;
    logic [31:0]         wbv;
    logic [31:0]         cp_word;
    logic                aborted;
    logic                offer;
    logic                mreq;
    logic [31:0]         maddr;
    logic [31:0]         dout;
    logic                wb_en;
    logic [31:0]         wb_val;
    logic                fwe;
    logic [3:0]          flags;
    logic                tabort;
    logic                tundef;
    logic                done;
    logic                busy;
    logic [3:0]          wreg;
  } cpt_ctrl_s;

  cpt_ctrl_s q_ff;
  cpt_ctrl_s nxt_q;

  logic [31:0] ag_base;
  logic [31:0] ag_first;
  logic [31:0] ag_wb;
  logic [31:0] mv_to_cp;
  logic        mv_pc_named;
  logic [3:0]  mv_flags;
  logic [2:0]  cls;
  logic        is_mem;
  logic        is_reg;
  logic        is_undef;
  logic        to_cpu;
  logic        pc_wback;

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  cpt_addr_gen u_addr (
    .instr      (q_ff.instr),
    .instr_addr (q_ff.pc),
    .base_value (q_ff.base),
    .base_eff   (ag_base),
    .first_addr (ag_first),
    .wb_value   (ag_wb)
  );

  cpt_move_word u_move (
    .instr         (q_ff.instr),
    .instr_addr    (q_ff.pc),
    .src_value     (src_value),
    .cp_word       (q_ff.cp_word),
    .to_cp_word    (mv_to_cp),
    .pc_named      (mv_pc_named),
    .flags_from_cp (mv_flags)
  );

  // Decode of the held instruction; class bits, bit 24, bit four, the direction bit and the base register field matter here.
  // A register transfer needs bit 24 clear, since the set case is another class.
  always_comb begin
    cls      = q_ff.instr[cpt_pkg::CLASS_HI:cpt_pkg::CLASS_LO];
    is_mem   = (cls == cpt_pkg::CLASS_MEM);
    is_reg   = (cls == cpt_pkg::CLASS_REG) && !q_ff.instr[cpt_pkg::BIT_RTX]
               && q_ff.instr[cpt_pkg::BIT_FOUR];
    is_undef = (cls == cpt_pkg::CLASS_UNDEF) && q_ff.instr[cpt_pkg::BIT_FOUR];
    to_cpu   = q_ff.instr[cpt_pkg::BIT_DIR];
    // Write-back into the program counter is undefined, so it is simply dropped.
    pc_wback = (q_ff.instr[cpt_pkg::REGN_HI:cpt_pkg::REGN_LO] == cpt_pkg::PC_REG_INDEX);
  end

  // ----------------------------------------------------------------
  // Sequencer.
  // ----------------------------------------------------------------
  // Pulses default low each cycle so wb_en, flags_we, done and both traps last exactly one cycle.
  always_comb begin
    nxt_q        = q_ff;
    nxt_q.wb_en  = 1'b0;
    nxt_q.fwe    = 1'b0;
    nxt_q.tabort = 1'b0;
    nxt_q.tundef = 1'b0;
    nxt_q.done   = 1'b0;
    case (q_ff.st)
      cpt_pkg::ST_IDLE: begin
        nxt_q.mreq = 1'b0;
        nxt_q.cyc  = cpt_pkg::CYC_S;
        if (instr_valid) begin
          nxt_q.instr   = instr_word;
          nxt_q.pc      = instr_addr;
          nxt_q.base    = base_value;
          nxt_q.aborted = 1'b0;
          nxt_q.offer   = 1'b1;
          nxt_q.st      = cpt_pkg::ST_OFFER;
        end
      end
      cpt_pkg::ST_OFFER: begin
        if (coproc_absent || is_undef) begin
          // Undefined pattern traps even if a coprocessor misbehaves.
          nxt_q.offer  = 1'b0;
          nxt_q.tundef = 1'b1;
          nxt_q.st     = cpt_pkg::ST_IDLE;
        end else if (coproc_busy) begin
          nxt_q.cyc = cpt_pkg::CYC_I;
        end else begin
          nxt_q.offer = 1'b0;
          if (is_mem) begin
            nxt_q.mreq  = 1'b1;
            nxt_q.maddr = ag_first;
            nxt_q.wbv   = ag_wb;
            nxt_q.cyc   = cpt_pkg::CYC_N;
            nxt_q.st    = cpt_pkg::ST_WORD;
          end else if (is_reg && to_cpu) begin
            nxt_q.cyc = cpt_pkg::CYC_I;
            nxt_q.st  = cpt_pkg::ST_MRC_I;
          end else if (is_reg) begin
            nxt_q.dout = mv_to_cp;
            nxt_q.cyc  = cpt_pkg::CYC_C;
            nxt_q.st   = cpt_pkg::ST_COP;
          end else begin
            nxt_q.cyc = cpt_pkg::CYC_S;
            nxt_q.st  = cpt_pkg::ST_FIN;
          end
        end
      end
      cpt_pkg::ST_WORD: begin
        // The abort is remembered so the transfer still closes normally.
        if (mem_abort) begin
          nxt_q.aborted = 1'b1;
        end
        if (coproc_last_word) begin
          nxt_q.mreq = 1'b0;
          nxt_q.cyc  = cpt_pkg::CYC_N;
          nxt_q.st   = cpt_pkg::ST_CLOSE;
        end else begin
          nxt_q.maddr = q_ff.maddr + cpt_pkg::WORD_BYTES;
          nxt_q.cyc   = cpt_pkg::CYC_S;
        end
      end
      cpt_pkg::ST_CLOSE: begin
        nxt_q.wb_en  = q_ff.instr[cpt_pkg::BIT_WBACK] && !pc_wback;
        nxt_q.wb_val = q_ff.wbv;
        nxt_q.tabort = q_ff.aborted;
        nxt_q.done   = !q_ff.aborted;
        nxt_q.cyc    = cpt_pkg::CYC_S;
        nxt_q.st     = cpt_pkg::ST_IDLE;
      end
      cpt_pkg::ST_MRC_I: begin
        nxt_q.cyc = cpt_pkg::CYC_C;
        nxt_q.st  = cpt_pkg::ST_COP;
      end
      cpt_pkg::ST_COP: begin
        nxt_q.cp_word = coproc_data_in;
        nxt_q.cyc     = cpt_pkg::CYC_S;
        nxt_q.st      = cpt_pkg::ST_FIN;
      end
      cpt_pkg::ST_FIN: begin
        if (is_reg && to_cpu && mv_pc_named) begin
          nxt_q.fwe   = 1'b1;
          nxt_q.flags = mv_flags;
        end else if (is_reg && to_cpu) begin
          nxt_q.wb_en  = 1'b1;
          nxt_q.wb_val = q_ff.cp_word;
        end
        nxt_q.done = 1'b1;
        nxt_q.st   = cpt_pkg::ST_IDLE;
      end
      default: begin
        nxt_q.st = cpt_pkg::ST_IDLE;
      end
    endcase
    // Derived outputs are registered too, so no port hangs off a gate.
    nxt_q.busy = (nxt_q.st != cpt_pkg::ST_IDLE);
    // Memory write-back targets the base; register moves target the named register.
    nxt_q.wreg = (nxt_q.instr[cpt_pkg::CLASS_HI:cpt_pkg::CLASS_LO] == cpt_pkg::CLASS_MEM)
                 ? nxt_q.instr[cpt_pkg::REGN_HI:cpt_pkg::REGN_LO]
                 : nxt_q.instr[cpt_pkg::REGD_HI:cpt_pkg::REGD_LO];
  end

  // Single register stage for the whole state record.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      q_ff         <= '0;
      q_ff.st      <= cpt_pkg::ST_IDLE;
      q_ff.cyc     <= cpt_pkg::CYC_S;
      q_ff.flags   <= cpt_pkg::FLAGS_RESET;
      q_ff.maddr   <= cpt_pkg::WORD_RESET;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the record.
  // ----------------------------------------------------------------
  assign ctrl_busy       = q_ff.busy;
  assign coproc_offer    = q_ff.offer;
  assign coproc_instr    = q_ff.instr;
  assign coproc_long     = q_ff.instr[cpt_pkg::BIT_LONG];
  assign coproc_data_out = q_ff.dout;
  assign mem_req         = q_ff.mreq;
  assign mem_addr        = q_ff.maddr;
  assign cycle_type      = q_ff.cyc;
  assign wb_en           = q_ff.wb_en;
  assign wb_reg          = q_ff.wreg;
  assign wb_value        = q_ff.wb_val;
  assign flags_we        = q_ff.fwe;
  assign flags_nzcv      = q_ff.flags;
  assign trap_data_abort = q_ff.tabort;
  assign trap_undef      = q_ff.tundef;
  assign done            = q_ff.done;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  sequence s_mrc_tail;
    cycle_type == cpt_pkg::CYC_I ##1 cycle_type == cpt_pkg::CYC_C ##1 cycle_type == cpt_pkg::CYC_S;
  endsequence

  sequence s_mcr_tail;
    cycle_type == cpt_pkg::CYC_C ##1 cycle_type == cpt_pkg::CYC_S;
  endsequence

  property p_low_bits;
    @(posedge sys_clk) disable iff (!resetn)
    $rose(mem_req) |-> mem_addr[1:0] == ag_base[1:0];
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("low address bits altered");

  property p_pc_base;
    @(posedge sys_clk) disable iff (!resetn)
    ($rose(mem_req) && pc_wback && !coproc_instr[cpt_pkg::BIT_PRE])
      |-> mem_addr == q_ff.pc + cpt_pkg::PC_BASE_ADD;
  endproperty
  a_pc_base: assert property (p_pc_base) else $error("pc base not plus eight");

  property p_abort_wb;
    @(posedge sys_clk) disable iff (!resetn)
    trap_data_abort |-> !done && !flags_we
      && (wb_en == (coproc_instr[cpt_pkg::BIT_WBACK] && !pc_wback));
  endproperty
  a_abort_wb: assert property (p_abort_wb) else $error("abort write-back wrong");

  property p_addr_step;
    @(posedge sys_clk) disable iff (!resetn)
    (mem_req && $past(mem_req)) |-> mem_addr == $past(mem_addr) + cpt_pkg::WORD_BYTES;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address step wrong");

  property p_flags;
    @(posedge sys_clk) disable iff (!resetn)
    flags_we |-> flags_nzcv == $past(coproc_data_in[31:28], 2) && !wb_en;
  endproperty
  a_flags: assert property (p_flags) else $error("flags not from top nibble");

  property p_pc_src;
    @(posedge sys_clk) disable iff (!resetn)
    (q_ff.st == cpt_pkg::ST_COP && !to_cpu && mv_pc_named)
      |-> coproc_data_out == q_ff.pc + 32'h0000_000C;
  endproperty
  a_pc_src: assert property (p_pc_src) else $error("pc source word not plus twelve");

  property p_mrc_time;
    @(posedge sys_clk) disable iff (!resetn)
    (q_ff.st == cpt_pkg::ST_OFFER && !coproc_absent && !coproc_busy && is_reg && to_cpu)
      |=> s_mrc_tail;
  endproperty
  a_mrc_time: assert property (p_mrc_time) else $error("cpu move order wrong");

  property p_mcr_time;
    @(posedge sys_clk) disable iff (!resetn)
    (q_ff.st == cpt_pkg::ST_OFFER && !coproc_absent && !coproc_busy && is_reg && !to_cpu)
      |=> s_mcr_tail;
  endproperty
  a_mcr_time: assert property (p_mcr_time) else $error("coproc move order wrong");

  property p_busy;
    @(posedge sys_clk) disable iff (!resetn)
    (q_ff.st == cpt_pkg::ST_OFFER && coproc_busy && !coproc_absent && !is_undef)
      |=> cycle_type == cpt_pkg::CYC_I && coproc_offer;
  endproperty
  a_busy: assert property (p_busy) else $error("busy did not stall");

  property p_undef;
    @(posedge sys_clk) disable iff (!resetn)
    (q_ff.st == cpt_pkg::ST_OFFER && coproc_absent) |=> trap_undef && !done ##1 !trap_undef;
  endproperty
  a_undef: assert property (p_undef) else $error("refused offer did not trap");

endmodule // cpt_ctrl

// >>> verilog/cpt_pkg.sv
package cpt_pkg;

  // ----------------------------------------------------------------
  // Word and address geometry.
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W        = 32;
  localparam logic [31:0] PC_BASE_ADD   = 32'h0000_0008;
  localparam logic [31:0] PC_STORE_ADD  = 32'h0000_000C;
  localparam logic [31:0] WORD_BYTES    = 32'h0000_0004;
  localparam int unsigned OFFSET_SHIFT  = 2;
  localparam logic [3:0]  PC_REG_INDEX  = 4'hF;

  // ----------------------------------------------------------------
  // Instruction field positions, plus the flag field of the coprocessor word.
  // ----------------------------------------------------------------
  localparam int unsigned CLASS_HI   = 27;
  localparam int unsigned CLASS_LO   = 25;
  localparam int unsigned BIT_PRE    = 24;
  localparam int unsigned BIT_UP     = 23;
  localparam int unsigned BIT_LONG   = 22;
  localparam int unsigned BIT_WBACK  = 21;
  localparam int unsigned BIT_DIR    = 20;
  localparam int unsigned REGN_HI    = 19;
  localparam int unsigned REGN_LO    = 16;
  localparam int unsigned REGD_HI    = 15;
  localparam int unsigned REGD_LO    = 12;
  localparam int unsigned OFFS_HI    = 7;
  localparam int unsigned OFFS_LO    = 0;
  localparam int unsigned BIT_RTX    = 24;
  localparam int unsigned BIT_FOUR   = 4;
  localparam int unsigned FLAG_HI    = 31;
  localparam int unsigned FLAG_LO    = 28;

  localparam logic [2:0] CLASS_MEM   = 3'h6;
  localparam logic [2:0] CLASS_REG   = 3'h7;
  localparam logic [2:0] CLASS_UNDEF = 3'h3;

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic [31:0] WORD_RESET  = 32'h0000_0000;
  localparam logic [3:0]  FLAGS_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Cycle kinds and controller states.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CYC_S, CYC_N, CYC_I, CYC_C} cpt_cycle_e;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OFFER, ST_WORD, ST_CLOSE, ST_MRC_I, ST_COP, ST_FIN
  } cpt_state_e;

endpackage : cpt_pkg

// >>> verilog/cpt_addr_gen.sv
// ------------------------------------------------------------------
// Address generation for memory transfers.
// ------------------------------------------------------------------
module cpt_addr_gen (
  input  wire logic [31:0] instr,
  input  wire logic [31:0] instr_addr,
  input  wire logic [31:0] base_value,
  output logic      [31:0] base_eff,
  output logic      [31:0] first_addr,
  output logic      [31:0] wb_value
);

  logic [31:0] offset_bytes;
  logic [31:0] modified;

  // The program counter as base reads ahead of the instruction by the pipeline depth.
  always_comb begin
    if (instr[cpt_pkg::REGN_HI:cpt_pkg::REGN_LO] == cpt_pkg::PC_REG_INDEX) begin
      base_eff = instr_addr + cpt_pkg::PC_BASE_ADD;
    end else begin
      base_eff = base_value;
    end
  end

  // The offset counts words, so it is scaled before it meets the byte address.
  always_comb begin
    offset_bytes = {22'h000000, instr[cpt_pkg::OFFS_HI:cpt_pkg::OFFS_LO], 2'h0};
    if (instr[cpt_pkg::BIT_UP]) begin
      modified = base_eff + offset_bytes;
    end else begin
      modified = base_eff - offset_bytes;
    end
    first_addr = instr[cpt_pkg::BIT_PRE] ? modified : base_eff;
    wb_value   = modified;
  end

endmodule // cpt_addr_gen

// >>> verilog/cpt_move_word.sv
// ------------------------------------------------------------------
// Word steering for register transfers.
// ------------------------------------------------------------------
module cpt_move_word (
  input  wire logic [31:0] instr,
  input  wire logic [31:0] instr_addr,
  input  wire logic [31:0] src_value,
  input  wire logic [31:0] cp_word,
  output logic      [31:0] to_cp_word,
  output logic             pc_named,
  output logic      [3:0]  flags_from_cp
);

  // Register field names the program counter in either direction.
  always_comb begin
    pc_named = (instr[cpt_pkg::REGD_HI:cpt_pkg::REGD_LO] == cpt_pkg::PC_REG_INDEX);
    if (pc_named) begin
      to_cp_word = instr_addr + cpt_pkg::PC_STORE_ADD;
    end else begin
      to_cp_word = src_value;
    end
    flags_from_cp = cp_word[cpt_pkg::FLAG_HI:cpt_pkg::FLAG_LO];
  end

endmodule // cpt_move_word

// >>> testbench/cpt_coproc_model.sv
// ------------------------------------------------------------------
// Behavioural coprocessor on the far side of the handshake.
// ------------------------------------------------------------------
module cpt_coproc_model (
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic        coproc_offer,
  input  wire logic [31:0] coproc_instr,
  input  wire logic        coproc_long,
  input  wire logic        mem_req,
  input  wire logic [1:0]  cycle_type,
  input  wire logic [3:0]  cfg_busy,
  input  wire logic [3:0]  cfg_words,
  input  wire logic [31:0] cfg_word,
  output logic             coproc_absent,
  output logic             coproc_busy,
  output logic             coproc_last_word,
  output logic      [31:0] coproc_data_in
);
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [3:0] OWN_NUM = 4'h7;

  logic [3:0] wait_cnt;
  logic [3:0] word_cnt;
  logic       tgl;
  logic       mine;
  logic       undef;

  // Counters restart with every offer, so a retried transfer repeats exactly.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wait_cnt <= 4'h0;
      word_cnt <= 4'h0;
      tgl      <= 1'b0;
    end else begin
      tgl      <= ~tgl;
      wait_cnt <= coproc_offer ? wait_cnt + 4'h1 : 4'h0;
      word_cnt <= mem_req ? word_cnt + 4'h1 : 4'h0;
    end
  end

  // Only this model reads the number field; the undefined pattern is decoded here and in the controller.
  assign mine  = (coproc_instr[11:8] == OWN_NUM);
  assign undef = (coproc_instr[27:25] == 3'h3) && coproc_instr[4];

  // Handshake lines nobody drives toggle and undriven data is inverted, so a stray sample is never a lucky value.
  assign coproc_absent  = coproc_offer ? (!mine || undef) : tgl;
  assign coproc_busy    = coproc_offer ? (undef || wait_cnt < cfg_busy) : ~tgl;
  assign coproc_last_word = mem_req ?
      (word_cnt == (coproc_long ? cfg_words : 4'h1) - 4'h1) : tgl;
  assign coproc_data_in = (cycle_type == cpt_pkg::CYC_C) ? cfg_word : ~cfg_word;
endmodule // cpt_coproc_model

// >>> testbench/coproc_transfer_control_bench.sv
module coproc_transfer_control_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        sys_clk, resetn, instr_valid, mem_abort;
  logic [31:0] instr_word, instr_addr, base_value, src_value, coproc_data_in;
  logic        coproc_absent, coproc_busy, coproc_last_word;
  logic        ctrl_busy, coproc_offer, coproc_long, mem_req, wb_en, flags_we;
  logic        trap_data_abort, trap_undef, done;
  logic [31:0] coproc_instr, coproc_data_out, mem_addr, wb_value;
  logic [1:0]  cycle_type;
  logic [3:0]  wb_reg, flags_nzcv, cfg_busy, cfg_words;
  logic [31:0] cfg_word;
  int          error_cnt, checks_done;
  int          n_cyc[4];
  logic [31:0] addr_q[$];
  logic [31:0] r_instr, r_dout, r_wb_val;
  logic [3:0]  r_wb_reg, r_flags;
  logic        r_long, r_wb, r_fwe, r_tda, r_tun, r_done;

  cpt_ctrl i_dut (.sys_clk, .resetn, .instr_valid, .instr_word, .instr_addr, .base_value,
    .src_value, .coproc_absent, .coproc_busy, .coproc_last_word, .coproc_data_in,
    .mem_abort, .ctrl_busy, .coproc_offer, .coproc_instr, .coproc_data_out, .coproc_long,
    .mem_req, .mem_addr, .cycle_type, .wb_en, .wb_reg, .wb_value, .flags_we, .flags_nzcv,
    .trap_data_abort, .trap_undef, .done);

  cpt_coproc_model i_cop (.sys_clk, .resetn, .coproc_offer, .coproc_instr, .coproc_long,
    .mem_req, .cycle_type, .cfg_busy, .cfg_words, .cfg_word, .coproc_absent, .coproc_busy,
    .coproc_last_word, .coproc_data_in);

  // 100 MHz clock.
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (error_cnt == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cnt_chk(input int s, input int n, input int i, input int c);
    chk(n_cyc[0], s, "S cycles");
    chk(n_cyc[1], n, "N cycles");
    chk(n_cyc[2], i, "I cycles");
    chk(n_cyc[3], c, "C cycles");
  endtask

  // Issues one instruction and logs cycle kinds, addresses and the closing pulses.
  // The offer cycle itself is not counted, being part of the base timing.
  task automatic run(input logic [31:0] iw, ia, bv, sv, input logic ab);
    int k;
    n_cyc = '{0, 0, 0, 0};
    addr_q = {};
    @(posedge sys_clk);
    instr_valid <= 1'b1;
    instr_word  <= iw;
    instr_addr  <= ia;
    base_value  <= bv;
    src_value   <= sv;
    mem_abort   <= ab;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    for (k = 0; k < 100; k++) begin
      @(negedge sys_clk);
      if (k == 0) begin
        r_instr = coproc_instr;
        r_long  = coproc_long;
        chk({coproc_offer, ctrl_busy}, 2'h3, "offer");
      end else if (ctrl_busy === 1'b1) begin
        n_cyc[cycle_type]++;
      end
      if (mem_req === 1'b1) addr_q.push_back(mem_addr);
      if (cycle_type === cpt_pkg::CYC_C) r_dout = coproc_data_out;
      if ((done | trap_undef | trap_data_abort) === 1'b1) break;
    end
    chk({k < 100, ctrl_busy}, 2'h2, "completion");
    {r_wb, r_wb_reg, r_wb_val, r_fwe, r_flags} = {wb_en, wb_reg, wb_value, flags_we, flags_nzcv};
    {r_tda, r_tun, r_done} = {trap_data_abort, trap_undef, done};
  endtask

  // ----------------------------------------------------------------
  // Scenarios.
  // ----------------------------------------------------------------
  task automatic t_mem(input logic p, u, w, nl, input logic [3:0] rn, input logic [31:0] bv,
                       ia, input logic [7:0] off, input int nw, b, input logic ab);
    logic [31:0] iw, be, md, fa;
    iw = {4'hE, 3'h6, p, u, nl, w, 1'b1, rn, 4'h2, 4'h7, off};
    be = (rn == 4'hF) ? ia + 32'h0000_0008 : bv;
    md = u ? be + {22'h0, off, 2'h0} : be - {22'h0, off, 2'h0};
    fa = p ? md : be;
    cfg_busy  = b[3:0];
    cfg_words = nw[3:0];
    run(iw, ia, bv, 32'h0, ab);
    chk(addr_q.size(), nw, "word count");
    foreach (addr_q[j]) chk(addr_q[j], fa + 32'(j) * 32'h4, "addr");
    cnt_chk(nw - 1, 2, b, 0);
    chk(r_long, nl, "long bit");
    chk(r_wb, w && rn != 4'hF, "write-back");
    if (w) chk(r_wb_val, md, "write-back value");
    if (w) chk(r_wb_reg, rn, "write-back index");
    chk(r_tda, ab, "abort trap");
    chk(r_done | r_fwe, !ab, "completion kind");
  endtask

  task automatic t_mrc(input logic [3:0] rd, input logic [31:0] word, input int b);
    logic [31:0] iw;
    iw = {4'hE, 4'hE, 3'h5, 1'b1, 4'hA, rd, 4'h7, 3'h3, 1'b1, 4'hC};
    cfg_busy = b[3:0];
    cfg_word = word;
    run(iw, 32'h0000_4000, 32'h0, 32'h0, 1'b0);
    chk(r_instr, iw, "fields passed");
    cnt_chk(1, 0, b + 1, 1);
    chk(r_fwe, rd == 4'hF, "flag write");
    if (rd == 4'hF) chk(r_flags, word[31:28], "flags");
    chk(r_wb, rd != 4'hF, "register write");
    if (rd != 4'hF) chk(r_wb_val, word, "register value");
    if (rd != 4'hF) chk(r_wb_reg, rd, "register index");
  endtask

  task automatic t_mcr(input logic [3:0] rd, input logic [31:0] sv, ia, input int b);
    logic [31:0] iw;
    iw = {4'hE, 4'hE, 3'h2, 1'b0, 4'h5, rd, 4'h7, 3'h6, 1'b1, 4'h3};
    cfg_busy = b[3:0];
    run(iw, ia, 32'h0, sv, 1'b0);
    chk(r_dout, (rd == 4'hF) ? ia + 32'h0000_000C : sv, "sent word");
    cnt_chk(1, 0, b, 1);
    chk(r_wb | r_fwe, 0, "no register write");
    chk(r_done, 1, "done");
  endtask

  task automatic t_undef(input logic [31:0] iw);
    cfg_busy = 4'h0;
    run(iw, 32'h0000_0100, 32'h0, 32'h0, 1'b0);
    chk(r_tun, 1, "undefined trap");
    chk(r_done | r_tda, 0, "no completion");
  endtask

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    {resetn, instr_valid, mem_abort} = 3'h0;
    {instr_word, instr_addr, base_value, src_value} = '0;
    {cfg_busy, cfg_words, cfg_word} = '0;
    error_cnt = 0;
    checks_done = 0;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    t_mem(1, 1, 1, 1, 4'h3, 32'h1000_0002, 32'h0, 8'h05, 3, 2, 0);
    t_mem(0, 0, 0, 0, 4'hF, 32'h5555_0000, 32'h2000, 8'h03, 1, 0, 0);
    t_mem(1, 0, 1, 0, 4'h6, 32'h0000_0301, 32'h0, 8'hFF, 1, 1, 1);
    t_mrc(4'h5, 32'hA5A5_1234, 1);
    t_mrc(4'hF, 32'h9FFF_FFFF, 0);
    t_mcr(4'h4, 32'h1234_5678, 32'h0000_0200, 3);
    t_mcr(4'hF, 32'hDEAD_0000, 32'h0000_0100, 0);
    t_undef({4'hE, 3'h3, 20'h12345, 1'b1, 4'h0});
    t_undef({4'hE, 4'hE, 3'h0, 1'b1, 4'h1, 4'h3, 4'h2, 3'h0, 1'b1, 4'h0});
    wrap_up();
  end

  // Watchdog well beyond the fewer than a hundred cycles the scenarios need.
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    wrap_up();
  end
endmodule // coproc_transfer_control_bench
